// ---- core/mon_pkg.sv ----
package mon_pkg;
  // Register offsets (byte addresses, 8-bit data)
  localparam logic [7:0] CHANNEL_SLOT_CONTROL_REGISTER = 8'h00;
  localparam logic [7:0] HANDSHAKE_CONTROL_REGISTER    = 8'h04;
  localparam logic [7:0] HANDSHAKE_STATUS_REGISTER     = 8'h08;
  localparam logic [7:0] CHANNEL_STATE_REGISTER        = 8'h0C;
  localparam logic [7:0] TRANSMIT_BYTE_REGISTER        = 8'h10;
  localparam logic [7:0] RECEIVE_BYTE_REGISTER         = 8'h14;
  localparam logic [7:0] CHANNEL_CONFIG_REGISTER       = 8'h18;
  // Slot control fields: [2:0] channel, [3] line select, [4] enable
  localparam int CH_LSB = 0;
  localparam int LINE_BIT = 3;
  localparam int EN_BIT = 4;
  localparam logic [7:0] SLOT_CTRL_RESET = 8'h10;
  // Handshake control bits
  localparam int TXC_BIT = 0;
  localparam int RXC_BIT = 1;
  localparam int IE_BIT = 2;
  localparam int RIE_BIT = 3;
  // Status bits
  localparam int ACK_BIT = 0;
  localparam int ABT_BIT = 1;
  localparam int RCV_BIT = 2;
  localparam int EOR_BIT = 3;
  // Config bits: [0] timeout enable, [1] terminal mode, [2] slave mode
  localparam int TIMEOUT_ENABLE_BIT_BIT = 0;
  localparam int TERM_BIT = 1;
  localparam int SLAVE_BIT = 2;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Frame layout: 32 bits per channel, 256 bits per frame (8 channels)
  localparam int CH_BITS = 32;
  localparam int MON_OFS = 16;
  localparam int HS_OFS = 30;
  localparam int TERM_CHANNELS = 3;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 5000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
endpackage

// ---- core/mon_slot_if.sv ----
`timescale 1ns/1ps
// Frame-level view of the message slot, one strobe per frame
interface mon_slot_if;
  logic       frame_done;
  logic [7:0] rx_byte;
  logic       rx_hs;
  logic       rx_peer;
  logic       collision;
  logic [7:0] tx_byte;
  logic       tx_hs;
  logic       tx_peer;
  modport shifter (output frame_done, rx_byte, rx_hs, rx_peer, collision,
                   input tx_byte, tx_hs, tx_peer);
  modport engine (input frame_done, rx_byte, rx_hs, rx_peer, collision,
                  output tx_byte, tx_hs, tx_peer);
endinterface

// ---- core/slot_shifter.sv ----
`timescale 1ns/1ps
// Finds bit clock and frame sync edges, shifts the selected slot in and out
module slot_shifter (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Slot configuration
  input  wire logic [2:0] channel,
  input  wire logic       line_up,
  input  wire logic       enable,
  // Bus pins
  input  wire logic       bit_clk,
  input  wire logic       frame_sync,
  input  wire logic       up_in,
  input  wire logic       down_in,
  output logic            up_out,
  output logic            up_oe,
  output logic            down_out,
  output logic            down_oe,
  // Frame-level view
  mon_slot_if.shifter     slot
);
  logic [1:0] s_clk, s_fs, s_up, s_dn;
  logic       clk_d, fs_seen;
  logic [7:0] bitpos, next_bitpos;
  logic [7:0] rx_sh, next_rx_sh;
  logic       hs_in, peer_in, next_hs_in, next_peer_in;
  logic       coll, next_coll, drv, next_drv, dval, next_dval;
  logic       next_frame_done;
  logic       rise, fall, din, rin;
  logic [7:0] base;
  logic [7:0] rel;

  assign rise = s_clk[1] & ~clk_d;
  assign fall = ~s_clk[1] & clk_d;
  // Own bits are checked on the driven line; the far side talks on the other one
  assign din  = line_up ? s_up[1] : s_dn[1];
  assign rin  = line_up ? s_dn[1] : s_up[1];
  assign base = {channel, 5'h00};
  // Index of the bit sampled at the coming rise or driven after this fall
  assign rel  = bitpos + 8'h01 - base;

  // Next values: drive on falling edge, sample on rising edge
  always_comb begin
    next_bitpos = bitpos;
    next_rx_sh = rx_sh;
    next_hs_in = hs_in;
    next_peer_in = peer_in;
    next_coll = coll;
    next_drv = drv;
    next_dval = dval;
    next_frame_done = 1'b0;
    if (rise) begin
      if (s_fs[1] && !fs_seen) begin
        next_bitpos = 8'h00;
        next_coll = 1'b0;
      end else begin
        next_bitpos = bitpos + 8'h01;
      end
    end
    if (fall && enable) begin
      next_drv = 1'b0;
      next_dval = 1'b1;
      if (rel >= 8'(mon_pkg::MON_OFS) && rel < 8'(mon_pkg::MON_OFS + 8)) begin
        next_drv = 1'b1;
        next_dval = slot.tx_byte[7 - (rel - 8'(mon_pkg::MON_OFS))];
      end else if (rel == 8'(mon_pkg::HS_OFS)) begin
        next_drv = 1'b1;
        next_dval = slot.tx_peer;
      end else if (rel == 8'(mon_pkg::HS_OFS + 1)) begin
        next_drv = 1'b1;
        next_dval = slot.tx_hs;
      end
    end
    if (rise && enable) begin
      // Bit-wise check of what we drove, except the peer bit, against the line
      if (drv && din != dval && rel != 8'(mon_pkg::HS_OFS)) begin
        next_coll = 1'b1;
      end
      if (rel >= 8'(mon_pkg::MON_OFS) && rel < 8'(mon_pkg::MON_OFS + 8)) begin
        next_rx_sh = {rx_sh[6:0], rin};
      end
      if (rel == 8'(mon_pkg::HS_OFS)) begin
        next_peer_in = rin;
      end
      if (rel == 8'(mon_pkg::HS_OFS + 1)) begin
        next_hs_in = rin;
        next_frame_done = 1'b1;
      end
    end
  end

  // Registers, synchronisers included
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_clk <= 2'b00;
      s_fs <= 2'b00;
      s_up <= 2'b11;
      s_dn <= 2'b11;
      clk_d <= 1'b0;
      fs_seen <= 1'b0;
      bitpos <= 8'h00;
      rx_sh <= 8'hFF;
      hs_in <= 1'b1;
      peer_in <= 1'b1;
      coll <= 1'b0;
      drv <= 1'b0;
      dval <= 1'b1;
      slot.frame_done <= 1'b0;
      slot.rx_byte <= 8'hFF;
      slot.rx_hs <= 1'b1;
      slot.rx_peer <= 1'b1;
      slot.collision <= 1'b0;
    end else begin
      s_clk <= {s_clk[0], bit_clk};
      s_fs <= {s_fs[0], frame_sync};
      s_up <= {s_up[0], up_in};
      s_dn <= {s_dn[0], down_in};
      clk_d <= s_clk[1];
      if (rise) begin
        fs_seen <= s_fs[1];
      end
      bitpos <= next_bitpos;
      rx_sh <= next_rx_sh;
      hs_in <= next_hs_in;
      peer_in <= next_peer_in;
      coll <= next_coll;
      drv <= next_drv;
      dval <= next_dval;
      slot.frame_done <= next_frame_done;
      if (next_frame_done) begin
        slot.rx_byte <= rx_sh;
        slot.rx_hs <= next_hs_in;
        slot.rx_peer <= peer_in;
        slot.collision <= next_coll; // Includes the check of the last own bit
      end
    end
  end

  // Own bits go out on the selected line only
  assign up_out   = dval;
  assign down_out = dval;
  assign up_oe    = drv & line_up;
  assign down_oe  = drv & ~line_up;
endmodule // slot_shifter

// ---- core/handshake_engine.sv ----
`timescale 1ns/1ps
module handshake_engine (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Frame bus pins
  input  wire logic       bit_clk,
  input  wire logic       frame_sync,
  input  wire logic       up_in,
  input  wire logic       down_in,
  output logic            up_out,
  output logic            up_oe,
  output logic            down_out,
  output logic            down_oe,
  // Strap
  input  wire logic       slave_strap
);
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_FIRST = 3'b001,
    TX_WAIT  = 3'b010,
    TX_GAP   = 3'b011,
    TX_END   = 3'b100
  } tx_state_t;

  mon_slot_if slot ();

  logic [7:0] slot_ctrl, ctrl, status, cfg, tx_byte, rx_byte;
  logic [7:0] next_slot_ctrl, next_ctrl, next_status, next_cfg, next_tx_byte, next_rx_byte;
  logic [7:0] next_rdata;
  tx_state_t  tx_st, next_tx_st;
  logic [1:0] end_cnt, next_end_cnt;
  logic       tx_hs, next_tx_hs, tx_new, next_tx_new;
  logic       rx_act, next_rx_act, rx_hs, next_rx_hs, rx_pend, next_rx_pend;
  logic       rx_first, next_rx_first, rx_gap, next_rx_gap;
  logic       rx_ack, next_rx_ack;
  logic [7:0] prev_byte, next_prev_byte;
  logic       prev_mx, next_prev_mx, prev_mr, next_prev_mr;
  logic       look_ok, next_look_ok;
  logic [31:0] tmr, next_tmr;
  logic       strap_done;
  logic       active;
  logic [2:0] ch_sel;
  logic       slave;

  // Terminal mode sends any selection past the three channels to channel 0
  assign ch_sel = (cfg[mon_pkg::TERM_BIT] &&
                   slot_ctrl[2:0] >= 3'(mon_pkg::TERM_CHANNELS)) ? 3'h0 : slot_ctrl[2:0];
  assign slave = cfg[mon_pkg::SLAVE_BIT];
  assign active = (tx_st != TX_IDLE) | rx_act;
  // An idle transmitter sends all ones so the slot reads as released
  assign slot.tx_byte = (tx_st == TX_IDLE) ? 8'hFF : tx_byte;
  assign slot.tx_hs = tx_hs;
  assign slot.tx_peer = rx_hs;

  slot_shifter u_shift (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .channel    (ch_sel),
    .line_up    (slot_ctrl[mon_pkg::LINE_BIT]),
    .enable     (slot_ctrl[mon_pkg::EN_BIT]),
    .bit_clk    (bit_clk),
    .frame_sync (frame_sync),
    .up_in      (up_in),
    .down_in    (down_in),
    .up_out     (up_out),
    .up_oe      (up_oe),
    .down_out   (down_out),
    .down_oe    (down_oe),
    .slot       (slot)
  );

  // Registers, transmit and receive machines; hardware sets win over clears
  always_comb begin
    next_slot_ctrl = slot_ctrl;
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_status = status;
    next_tx_byte = tx_byte;
    next_rx_byte = rx_byte;
    next_tx_st = tx_st;
    next_end_cnt = end_cnt;
    next_tx_hs = tx_hs;
    next_tx_new = tx_new;
    next_rx_act = rx_act;
    next_rx_hs = rx_hs;
    next_rx_pend = rx_pend;
    next_rx_ack = rx_ack;
    next_rx_first = rx_first;
    next_rx_gap = rx_gap;
    next_prev_byte = prev_byte;
    next_prev_mx = prev_mx;
    next_prev_mr = prev_mr;
    next_look_ok = look_ok;
    next_tmr = tmr;
    next_rdata = 8'h00;
    // Host reads; status clears on read
    if (rd) begin
      unique case (addr)
        mon_pkg::CHANNEL_SLOT_CONTROL_REGISTER: next_rdata = slot_ctrl;
        mon_pkg::HANDSHAKE_CONTROL_REGISTER:    next_rdata = ctrl;
        mon_pkg::HANDSHAKE_STATUS_REGISTER: begin
          next_rdata = status;
          next_status = 8'h00;
        end
        mon_pkg::CHANNEL_STATE_REGISTER:        next_rdata = {7'h00, active};
        mon_pkg::TRANSMIT_BYTE_REGISTER:        next_rdata = tx_byte;
        mon_pkg::RECEIVE_BYTE_REGISTER: begin
          next_rdata = rx_byte;
          next_rx_pend = 1'b0;
          next_rx_ack = rx_pend | rx_ack;
        end
        mon_pkg::CHANNEL_CONFIG_REGISTER:       next_rdata = cfg;
        default:                                next_rdata = 8'h00;
      endcase
    end
    // Host writes
    if (wr) begin
      unique case (addr)
        mon_pkg::CHANNEL_SLOT_CONTROL_REGISTER: next_slot_ctrl = {3'h0, wdata[4:0]};
        mon_pkg::HANDSHAKE_CONTROL_REGISTER:    next_ctrl = {4'h0, wdata[3:0]};
        mon_pkg::TRANSMIT_BYTE_REGISTER: begin
          next_tx_byte = wdata;
          next_tx_new = 1'b1;
        end
        mon_pkg::CHANNEL_CONFIG_REGISTER:       next_cfg = {5'h00, wdata[2:0]};
        default: ;
      endcase
    end
    // Reply timer, runs only while waiting for an acknowledge
    if ((tx_st == TX_FIRST || tx_st == TX_WAIT) && cfg[mon_pkg::TIMEOUT_ENABLE_BIT_BIT]) begin
      next_tmr = tmr + 32'h1;
    end else begin
      next_tmr = 32'h0;
    end
    if (slot.frame_done) begin
      next_prev_byte = slot.rx_byte;
      next_prev_mx = slot.rx_hs;
      next_prev_mr = slot.rx_peer;
      // Double look on data and the far transmit bit
      next_look_ok = (slot.rx_byte == prev_byte) && (slot.rx_hs == prev_mx);
      // Transmit path
      unique case (tx_st)
        TX_IDLE: begin
          if (ctrl[mon_pkg::TXC_BIT] && tx_new) begin
            next_tx_hs = 1'b0;
            next_tx_new = 1'b0;
            next_tx_st = TX_FIRST;
          end
        end
        TX_FIRST, TX_WAIT: begin
          // The first byte waits for the opening acknowledge with no abort on a high peer bit; only a collision, the reply timer or a cleared transmit control ends it
          if (slot.collision ||
              (tmr >= 32'(mon_pkg::TIMEOUT_CYCLES))) begin
            next_tx_hs = 1'b1;
            next_end_cnt = 2'd0;
            next_tx_st = TX_END;
            next_status[mon_pkg::ABT_BIT] = 1'b1;
          end else if (slot.rx_peer && prev_mr && tx_st == TX_WAIT) begin
            next_tx_hs = 1'b1;
            next_end_cnt = 2'd0;
            next_tx_st = TX_END;
            next_status[mon_pkg::ABT_BIT] = 1'b1;
          end else if (!slot.rx_peer && (prev_mr || tx_st == TX_FIRST)) begin
            next_status[mon_pkg::ACK_BIT] = 1'b1;
            next_tx_st = TX_WAIT;
            if (!ctrl[mon_pkg::TXC_BIT]) begin
              next_tx_hs = 1'b1;
              next_end_cnt = 2'd0;
              next_tx_st = TX_END;
            end else if (tx_new) begin
              next_tx_hs = 1'b1;
              next_tx_new = 1'b0;
              next_tx_st = TX_GAP;
            end
          end else if (!ctrl[mon_pkg::TXC_BIT]) begin
            next_tx_hs = 1'b1;
            next_end_cnt = 2'd0;
            next_tx_st = TX_END;
          end
          // Otherwise the same byte repeats with the bit low
        end
        TX_GAP: begin
          next_tx_hs = 1'b0;
          next_tx_st = TX_WAIT;
        end
        TX_END: begin
          next_tx_hs = 1'b1;
          if (end_cnt != 2'd2) begin
            next_end_cnt = end_cnt + 2'd1;
          end
          if (end_cnt != 2'd0 && !ctrl[mon_pkg::TXC_BIT] && slot.rx_peer) begin
            next_tx_st = TX_IDLE;
          end
        end
        default: next_tx_st = TX_IDLE;
      endcase
      // Receive path
      next_rx_hs = 1'b1;
      if (slot.rx_hs && prev_mx) begin
        if (rx_act) begin
          next_status[mon_pkg::EOR_BIT] = 1'b1;
        end
        next_rx_act = 1'b0;
        next_rx_first = 1'b0;
      end else if (!slot.rx_hs && prev_mx && !next_look_ok) begin
        next_look_ok = 1'b0; // Waits for a second identical frame
      end else if (!slot.rx_hs && next_look_ok) begin
        if (!rx_act && !rx_first) begin
          next_rx_byte = slot.rx_byte;
          next_rx_first = 1'b1;
          next_rx_pend = 1'b1;
          next_rx_gap = 1'b0;
          if (ctrl[mon_pkg::RIE_BIT]) begin
            next_status[mon_pkg::RCV_BIT] = 1'b1;
          end
        end else if (rx_act && rx_gap) begin
          next_rx_byte = slot.rx_byte;
          next_rx_pend = 1'b1;
          next_rx_gap = 1'b0;
          if (ctrl[mon_pkg::RIE_BIT] && ctrl[mon_pkg::RXC_BIT]) begin
            next_status[mon_pkg::RCV_BIT] = 1'b1;
          end
        end
      end else if (slot.rx_hs && rx_act) begin
        next_rx_gap = 1'b1;
      end
      if (ctrl[mon_pkg::RXC_BIT] && (rx_first || rx_act)) begin
        next_rx_act = 1'b1;
        next_rx_first = 1'b0;
        // Bit high for one frame marks the acknowledge of a new read
        // Bit stays active while a byte waits unread, so the sender stalls
        next_rx_hs = rx_ack;
        if (rx_ack) begin
          next_rx_ack = 1'b0;
        end
      end
      if (!ctrl[mon_pkg::RXC_BIT] && rx_act) begin
        next_rx_hs = 1'b1;
        next_rx_act = !(slot.rx_hs && prev_mx);
      end
      if (slave && rx_act && slot.collision) begin
        next_rx_hs = 1'b1;
      end
    end
  end

  // Plain registers only; the strap is caught after reset release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_ctrl <= mon_pkg::SLOT_CTRL_RESET;
      ctrl <= 8'h00;
      cfg <= mon_pkg::CONFIG_RESET;
      status <= 8'h00;
      tx_byte <= 8'hFF;
      rx_byte <= 8'hFF;
      rdata <= 8'h00;
      tx_st <= TX_IDLE;
      end_cnt <= 2'd0;
      tx_hs <= 1'b1;
      tx_new <= 1'b0;
      rx_act <= 1'b0;
      rx_hs <= 1'b1;
      rx_pend <= 1'b0;
      rx_ack <= 1'b0;
      rx_first <= 1'b0;
      rx_gap <= 1'b0;
      prev_byte <= 8'hFF;
      prev_mx <= 1'b1;
      prev_mr <= 1'b1;
      look_ok <= 1'b0;
      tmr <= 32'h0;
      strap_done <= 1'b0;
    end else begin
      slot_ctrl <= next_slot_ctrl;
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      strap_done <= 1'b1;
      if (!strap_done) begin
        cfg[mon_pkg::SLAVE_BIT] <= slave_strap;
      end
      status <= next_status;
      tx_byte <= next_tx_byte;
      rx_byte <= next_rx_byte;
      rdata <= next_rdata;
      tx_st <= next_tx_st;
      end_cnt <= next_end_cnt;
      tx_hs <= next_tx_hs;
      tx_new <= next_tx_new;
      rx_act <= next_rx_act;
      rx_hs <= next_rx_hs;
      rx_pend <= next_rx_pend;
      rx_ack <= next_rx_ack;
      rx_first <= next_rx_first;
      rx_gap <= next_rx_gap;
      prev_byte <= next_prev_byte;
      prev_mx <= next_prev_mx;
      prev_mr <= next_prev_mr;
      look_ok <= next_look_ok;
      tmr <= next_tmr;
    end
  end
endmodule // handshake_engine

// ---- bench/engine_chk.sv ----
`timescale 1ns/1ps
// Watches the register port and the line drivers of the handshake engine
module engine_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Frame bus pins
  input wire logic       bit_clk,
  input wire logic       frame_sync,
  input wire logic       up_in,
  input wire logic       down_in,
  input wire logic       up_out,
  input wire logic       up_oe,
  input wire logic       down_out,
  input wire logic       down_oe,
  // Strap
  input wire logic       slave_strap
);
  logic [4:0]  slot_q;
  logic [3:0]  ctrl_q;
  logic [1:0]  cfg_q;
  logic [13:0] idle_cnt;

  // Shadows of written fields; the idle count saturates so it never wraps
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_q   <= 5'h10;
      ctrl_q   <= 4'h0;
      cfg_q    <= 2'h0;
      idle_cnt <= 14'h0000;
    end else begin
      if (wr && addr == mon_pkg::CHANNEL_SLOT_CONTROL_REGISTER) slot_q <= wdata[4:0];
      if (wr && addr == mon_pkg::HANDSHAKE_CONTROL_REGISTER) ctrl_q <= wdata[3:0];
      if (wr && addr == mon_pkg::CHANNEL_CONFIG_REGISTER) cfg_q <= wdata[1:0];
      idle_cnt <= (ctrl_q[1:0] != 2'h0) ? 14'h0000 : idle_cnt + {13'h0000, idle_cnt != 14'h3FFF};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // A read request to one offset
  sequence rd_of(logic [7:0] a);
    rd && addr == a;
  endsequence

  chk_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property (rd_of(8'h1C) |=> rdata == 8'h00)
    else $error("unmapped offset read not zero");
  chk_slot_readback: assert property (
    rd_of(mon_pkg::CHANNEL_SLOT_CONTROL_REGISTER) |=> rdata[4:0] == slot_q)
    else $error("slot control read differs from last write");
  chk_ctrl_readback: assert property (
    rd_of(mon_pkg::HANDSHAKE_CONTROL_REGISTER) |=> rdata[3:0] == ctrl_q)
    else $error("handshake control read differs from last write");
  chk_cfg_readback: assert property (
    rd_of(mon_pkg::CHANNEL_CONFIG_REGISTER) |=> rdata[1:0] == cfg_q)
    else $error("config read differs from last write");
  chk_strap_mode: assert property (
    rd_of(mon_pkg::CHANNEL_CONFIG_REGISTER) |=> rdata[mon_pkg::SLAVE_BIT] == slave_strap)
    else $error("slave mode bit differs from strap");
  chk_state_spare: assert property (
    rd_of(mon_pkg::CHANNEL_STATE_REGISTER) |=> rdata[7:1] == 7'h00)
    else $error("state register spare bits set");
  chk_status_spare: assert property (
    rd_of(mon_pkg::HANDSHAKE_STATUS_REGISTER) |=> rdata[7:4] == 4'h0)
    else $error("status register spare bits set");
  chk_up_quiet: assert property (!slot_q[3] |-> !up_oe)
    else $error("upstream line driven while downstream selected");
  chk_master_idle: assert property (
    idle_cnt > 14'd9000 |-> !(down_oe && !down_out))
    else $error("line pulled low with both handshake controls off");
endmodule // engine_chk

// ---- bench/far_device.sv ----
`timescale 1ns/1ps
// Far device on channel 0: makes bus timing, receives downstream, sends upstream
module far_device (
  // Bus timing
  output logic       bit_clk,
  output logic       frame_sync,
  // Line levels
  input  wire logic  down_line,
  output logic       up_drive,
  // Scenario control
  input  wire logic       tx_on,
  input  wire logic [7:0] tx_byte,
  // Frame observations
  output logic [7:0] seen_byte,
  output logic       seen_mx,
  output logic       seen_mr,
  output logic       mr_out,
  output int         frames
);
  logic [7:0] bit_idx;
  logic [7:0] shift_in;
  logic [7:0] last_byte;
  logic [7:0] out_byte;
  logic       last_mx;
  logic       out_mx;

  // Free-running bit clock, phase unrelated to the system clock
  initial begin
    bit_clk    = 1'b0;
    bit_idx    = 8'hFF;
    frame_sync = 1'b0;
    seen_byte  = 8'h00;
    seen_mx    = 1'b1;
    seen_mr    = 1'b1;
    mr_out     = 1'b1;
    frames     = 0;
    last_mx    = 1'b1;
    last_byte  = 8'h00;
    out_byte   = 8'hFF;
    out_mx     = 1'b1;
    shift_in   = 8'h00;
    #37;
    forever #80 bit_clk = ~bit_clk;
  end

  // Present the next bit on the falling edge; slot content fixed per frame
  always @(negedge bit_clk) begin
    bit_idx    <= bit_idx + 8'h01;
    frame_sync <= (bit_idx == 8'hFF);
    if (bit_idx == 8'hFF) out_byte <= tx_on ? tx_byte : 8'hFF;
    if (bit_idx == 8'hFF) out_mx <= ~tx_on;
  end

  // Released bits float high through the pull-up
  always_comb begin
    up_drive = 1'b1;
    if (bit_idx >= 8'd16 && bit_idx <= 8'd23) up_drive = out_byte[3'(8'd23 - bit_idx)];
    if (bit_idx == 8'd30) up_drive = mr_out;
    if (bit_idx == 8'd31) up_drive = out_mx;
  end

  // Sample on the rising edge; acknowledge only a byte seen twice alike
  always @(posedge bit_clk) begin
    if (bit_idx >= 8'd16 && bit_idx <= 8'd23) shift_in <= {shift_in[6:0], down_line};
    if (bit_idx == 8'd30) seen_mr <= down_line;
    if (bit_idx == 8'd31) begin
      seen_byte <= shift_in;
      seen_mx   <= down_line;
      last_byte <= shift_in;
      last_mx   <= down_line;
      frames    <= frames + 1;
      if (down_line) mr_out <= 1'b1;
      else if (!last_mx && last_byte == shift_in) mr_out <= 1'b0;
    end
  end
endmodule // far_device

// ---- bench/monitor_channel_handshake_bench.sv ----
`timescale 1ns/1ps
// Host sequences against the engine with a far device on the frame bus
module monitor_channel_handshake_bench;
  // Clock, reset and register port
  logic       sys_clk;
  logic       resetn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  // Frame bus
  logic       bit_clk;
  logic       frame_sync;
  logic       up_line;
  logic       down_line;
  logic       up_out;
  logic       up_oe;
  logic       down_out;
  logic       down_oe;
  logic       up_drive;
  // Far device control and view
  logic       p_tx_on;
  logic [7:0] p_tx_byte;
  logic [7:0] seen_byte;
  logic       seen_mx;
  logic       seen_mr;
  int         frames;
  int         num_errors;
  int         samples_checked;

  // Open-drain style lines: a released driver leaves the pull-up level
  assign down_line = down_oe ? down_out : 1'b1;
  assign up_line   = up_drive & (up_oe ? up_out : 1'b1);

  handshake_engine handshake_engine_inst (
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bit_clk(bit_clk), .frame_sync(frame_sync), .up_in(up_line),
    .down_in(down_line), .up_out(up_out), .up_oe(up_oe), .down_out(down_out),
    .down_oe(down_oe), .slave_strap(1'b0));

  far_device far_device_inst (
    .bit_clk(bit_clk), .frame_sync(frame_sync), .down_line(down_line), .up_drive(up_drive),
    .tx_on(p_tx_on), .tx_byte(p_tx_byte), .seen_byte(seen_byte), .seen_mx(seen_mx),
    .seen_mr(seen_mr), .mr_out(), .frames(frames));

  // System clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    check_val(rdata & mask, exp);
  endtask

  // Bounded wait on whole frames seen by the far device
  task automatic wait_frames(input int n);
    int target;
    int guard;
    target = frames + n;
    guard  = 0;
    while (frames < target && guard < n * 5000) begin
      @(posedge sys_clk);
      guard++;
    end
    if (frames < target) begin
      num_errors++;
      $display("[FAIL] %0t frame wait ran out", $time);
      complete_run();
    end
  endtask

  // Main sequence: reset table, then a two-way message on channel 0
  initial begin
    resetn          = 1'b0;
    addr            = 8'h00;
    wdata           = 8'h00;
    wr              = 1'b0;
    rd              = 1'b0;
    p_tx_on         = 1'b0;
    p_tx_byte       = 8'hFF;
    num_errors      = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    // Offsets step by four; both byte registers idle at all ones; the eighth reads zero
    for (int i = 0; i < 8; i++) begin
      check_reg(8'(4*i), (i == 0) ? mon_pkg::SLOT_CTRL_RESET : {8{i/2 == 2}}, 8'hFF);
    end
    reg_write(mon_pkg::HANDSHAKE_CONTROL_REGISTER, 8'h0C);
    reg_write(mon_pkg::TRANSMIT_BYTE_REGISTER, 8'hA5);
    reg_write(mon_pkg::HANDSHAKE_CONTROL_REGISTER, 8'h0D);
    // Far side opens with a stray byte for one whole frame; only the repeated one counts
    wait_frames(1);
    @(posedge sys_clk);
    p_tx_byte <= 8'h5A;
    p_tx_on   <= 1'b1;
    wait_frames(1);
    @(posedge sys_clk);
    p_tx_byte <= 8'h3C;
    wait_frames(4);
    check_val(seen_byte, 8'hA5);
    check_val({7'h00, seen_mx}, 8'h00);
    check_reg(mon_pkg::HANDSHAKE_STATUS_REGISTER, 8'h05, 8'hFF);
    check_reg(mon_pkg::CHANNEL_STATE_REGISTER, 8'h01, 8'h01);
    check_reg(mon_pkg::RECEIVE_BYTE_REGISTER, 8'h3C, 8'hFF);
    reg_write(mon_pkg::HANDSHAKE_CONTROL_REGISTER, 8'h0F);
    wait_frames(3);
    check_val({7'h00, seen_mr}, 8'h00);
    check_val(seen_byte, 8'hA5);
    reg_write(mon_pkg::HANDSHAKE_CONTROL_REGISTER, 8'h0E);
    wait_frames(3);
    check_val({7'h00, seen_mx}, 8'h01);
    @(posedge sys_clk);
    p_tx_on <= 1'b0;
    wait_frames(3);
    check_reg(mon_pkg::HANDSHAKE_STATUS_REGISTER, 8'h08, 8'h08);
    reg_write(mon_pkg::HANDSHAKE_CONTROL_REGISTER, 8'h0C);
    wait_frames(3);
    check_val({7'h00, seen_mr}, 8'h01);
    check_reg(mon_pkg::CHANNEL_STATE_REGISTER, 8'h00, 8'h01);
    complete_run();
  end
endmodule // monitor_channel_handshake_bench

bind handshake_engine engine_chk engine_chk_inst (
  .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .bit_clk(bit_clk), .frame_sync(frame_sync), .up_in(up_in),
  .down_in(down_in), .up_out(up_out), .up_oe(up_oe), .down_out(down_out),
  .down_oe(down_oe), .slave_strap(slave_strap));
